/* File: design/bds_pkg.sv */
package bds_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_DIAG_CFG     = 8'h00;
    localparam logic [7:0] OFS_SCAN_CTRL    = 8'h04;
    localparam logic [7:0] OFS_ALERT_CFG    = 8'h08;
    localparam logic [7:0] OFS_TEMP_THRESH  = 8'h0C;
    localparam logic [7:0] OFS_OPEN_THRESH  = 8'h10;
    localparam logic [7:0] OFS_BIPOLAR_MASK = 8'h14;
    localparam logic [7:0] OFS_CTEST_CFG    = 8'h18;
    localparam logic [7:0] OFS_RESULT_A     = 8'h1C;
    localparam logic [7:0] OFS_RESULT_B     = 8'h20;
    localparam logic [7:0] OFS_FAULT_ONE    = 8'h24;
    localparam logic [7:0] OFS_FAULT_TWO    = 8'h28;
    localparam logic [7:0] OFS_BALSW_ALERT  = 8'h2C;
    localparam logic [7:0] OFS_COMP_OV      = 8'h30;
    localparam logic [7:0] OFS_COMM_STATUS  = 8'h34;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int DIAG_SEL_B_LSB      = 4;
    localparam int ACFG_IFSEL_BIT      = 0;
    localparam int ACFG_DCTEST_BIT     = 1;
    localparam int ACFG_USER_BIT       = 2;
    localparam int ACFG_CALEN_BIT      = 3;
    localparam int ACFG_OPENSEL_BIT    = 4;
    localparam int SCAN_START_BIT      = 4;
    localparam int CTEST_DAC_LSB       = 16;
    localparam int RESULT_LSB          = 2;
    localparam int F1_SUMMARY_BIT      = 0;
    localparam int F1_SUPPLY_MUX_BIT   = 1;
    localparam int F2_TEMP_BIT         = 0;
    localparam int F2_ACC_OV_BIT       = 1;
    localparam int F2_ACC_UV_BIT       = 2;
    localparam int COMM_UPPER_BIT      = 0;
    localparam int COMM_LOWER_BIT      = 1;

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [3:0] DSEL_NONE      = 4'h0;
    localparam logic [3:0] DSEL_PTAT      = 4'h1;
    localparam logic [3:0] DSEL_SUPPLY    = 4'h2;
    localparam logic [3:0] DSEL_ALTERNATE_REFERENCE    = 4'h3;
    localparam logic [3:0] DSEL_DAC_HIGH  = 4'h7;
    localparam logic [3:0] DSEL_DAC_LOW   = 4'h8;
    localparam logic [3:0] DSEL_THRM_OFS  = 4'h9;
    localparam logic [3:0] DSEL_ZERO      = 4'hA;
    localparam logic [3:0] DSEL_FULL      = 4'hB;
    localparam logic [3:0] DSEL_AMP_OFS   = 4'hC;
    localparam logic [2:0] SCAN_COMP      = 3'h2;
    localparam logic [2:0] SCAN_SW_SHORT  = 3'h4;
    localparam logic [2:0] SCAN_SW_OPEN   = 3'h5;
    localparam logic [2:0] SCAN_ODD_OPEN  = 3'h6;
    localparam logic [2:0] SCAN_EVEN_OPEN = 3'h7;
    localparam logic [13:0] DAC_HIGH_CODE = 14'h06EC;
    localparam logic [13:0] DAC_LOW_CODE  = 14'h024F;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ           = 200;
    localparam int TEMP_PERIOD_US    = 1000;
    localparam int TEMP_PERIOD_CYC   = TEMP_PERIOD_US * CLK_MHZ;
    localparam int SETTLE_NS         = 39000;
    localparam int SETTLE_CYC        = (SETTLE_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [13:0] code;
    } bds_adc_type;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SETTLE = 2'b01,
        ST_CONV   = 2'b10
    } bds_state_type;

endpackage : bds_pkg

/* File: design/bds_top.sv */
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module bds_top #(
    parameter int NCELL        = 14,
    parameter int TEMP_PERIOD  = bds_pkg::TEMP_PERIOD_CYC,
    parameter int SETTLE       = bds_pkg::SETTLE_CYC
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // Avalon-MM slave
    input  wire logic [7:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // Analog front end
    output logic      [3:0]           adc_mux_select,
    output logic                      adc_start,
    output logic                      adc_ref_supply,
    output logic                      adc_force_unipolar,
    output logic      [13:0]          dac_code,
    input  wire bds_pkg::bds_adc_type adc_result,
    input  wire logic [13:0]          die_temp_code,
    input  wire logic [13:0]          acc_code,
    input  wire logic                 acq_done,
    input  wire logic [13:0]          cell_code [NCELL],
    input  wire logic                 comp_scan_done,
    // Balancing switch test front end
    output logic      [2:0]           balsw_mode,
    input  wire logic [NCELL-1:0]     balsw_fail,
    input  wire logic                 balsw_done,
    output logic      [NCELL-1:0]     pulldown_enable,
    output logic      [3:0]           pulldown_level,
    // Pin and fault inputs from outside the clock domain
    input  wire logic                 rx_upper_ok_pin,
    input  wire logic                 rx_lower_ok_pin,
    input  wire logic                 flex_pack_fault_pin,
    input  wire logic                 alert_condition,
    // Alert output pin
    output logic                      alert_output_pin_o,
    output logic                      alert_output_pin_oe
);

    // ------------------------------------------------------------------
    // Reset and synchronisers
    // ------------------------------------------------------------------
    logic       rst_s1_r, rst_b_r;
    logic [2:0] pin_s1_r, pin_s2_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_r <= 1'b0;
            rst_b_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_b_r  <= rst_s1_r;
        end
    end

    // The pin synchroniser runs through reset, so the receive-port check sees settled pins.
    always_ff @(posedge clk) begin
        pin_s1_r <= {flex_pack_fault_pin, rx_lower_ok_pin, rx_upper_ok_pin};
        pin_s2_r <= pin_s1_r;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]       diag_cfg_r, diag_cfg_nxt;
    logic [3:0]       scan_ctrl_r, scan_ctrl_nxt;
    logic [4:0]       alert_cfg_r, alert_cfg_nxt;
    logic [13:0]      temp_thresh_r, temp_thresh_nxt;
    logic [13:0]      open_thresh_r, open_thresh_nxt;
    logic [NCELL-1:0] bipolar_r, bipolar_nxt;
    logic [NCELL-1:0] ctest_en_r, ctest_en_nxt;
    logic [3:0]       ctest_dac_r, ctest_dac_nxt;
    logic [15:0]      result_a_r, result_a_nxt;
    logic [15:0]      result_b_r, result_b_nxt;
    logic [1:0]       fault_one_r, fault_one_nxt;
    logic [2:0]       fault_two_r, fault_two_nxt;
    logic [NCELL-1:0] balsw_r, balsw_nxt;
    logic [NCELL-1:0] comp_ov_r, comp_ov_nxt;
    logic [1:0]       comm_r, comm_nxt;
    logic             comm_checked_r, comm_checked_nxt;
    logic             scan_start_r, scan_start_nxt;
    logic [31:0]      rdata_r, rdata_nxt;
    logic             ack_r, ack_nxt;

    logic [3:0] sel_a, sel_b;
    logic       uart_mode, dc_test, open_diag, temp_suspend;
    logic       wr_en, rd_en;
    logic [NCELL-1:0] open_hits;
    logic [31:0]      wmask;

    // Diagnostic sequencer signals.
    bds_pkg::bds_state_type st_r, st_nxt;
    logic        slot_r, slot_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [31:0] tick_r, tick_nxt;
    logic        conv_done;

    assign sel_a        = diag_cfg_r[3:0];
    assign sel_b        = diag_cfg_r[bds_pkg::DIAG_SEL_B_LSB +: 4];
    assign uart_mode    = alert_cfg_r[bds_pkg::ACFG_IFSEL_BIT];
    assign dc_test      = uart_mode & alert_cfg_r[bds_pkg::ACFG_DCTEST_BIT];
    assign open_diag    = alert_cfg_r[bds_pkg::ACFG_OPENSEL_BIT]
                          & (scan_ctrl_r[2:0] == bds_pkg::SCAN_COMP);
    assign temp_suspend = (sel_a == bds_pkg::DSEL_PTAT) | (sel_b == bds_pkg::DSEL_PTAT);
    // A write lands only at the edge that completes the access, with waitrequest low.
    assign wr_en        = avs_write & ack_r;
    assign rd_en        = avs_read & ~ack_r;
    assign conv_done    = (st_r == bds_pkg::ST_CONV) & adc_result.valid
                          & ((slot_r ? sel_b : sel_a) != bds_pkg::DSEL_NONE);

    // Each access is answered one cycle after it is presented.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign avs_readdata    = rdata_r;

    generate
        for (genvar i = 0; i < NCELL; i++) begin : g_cell
            assign open_hits[i] = ~bipolar_r[i] & (cell_code[i] < open_thresh_r);
        end
        for (genvar b = 0; b < 4; b++) begin : g_mask
            assign wmask[8*b +: 8] = {8{avs_byteenable[b]}};
        end
    endgenerate

    // ------------------------------------------------------------------
    // Register file next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0] wd;
        wd               = avs_writedata & wmask;
        diag_cfg_nxt     = diag_cfg_r;
        scan_ctrl_nxt    = scan_ctrl_r;
        alert_cfg_nxt    = alert_cfg_r;
        temp_thresh_nxt  = temp_thresh_r;
        open_thresh_nxt  = open_thresh_r;
        bipolar_nxt      = bipolar_r;
        ctest_en_nxt     = ctest_en_r;
        ctest_dac_nxt    = ctest_dac_r;
        result_a_nxt     = result_a_r;
        result_b_nxt     = result_b_r;
        fault_one_nxt    = fault_one_r;
        fault_two_nxt    = fault_two_r;
        balsw_nxt        = balsw_r;
        comp_ov_nxt      = comp_ov_r;
        comm_nxt         = comm_r;
        comm_checked_nxt = 1'b1;
        scan_start_nxt   = 1'b0;
        ack_nxt          = (avs_read | avs_write) & ~ack_r;
        rdata_nxt        = rdata_r;

        // Software clears status bits by writing ones; hardware sets after, so a set wins.
        if (wr_en) begin
            case (avs_address)
                bds_pkg::OFS_DIAG_CFG:     diag_cfg_nxt    = wd[7:0];
                bds_pkg::OFS_SCAN_CTRL: begin
                    scan_ctrl_nxt  = wd[3:0];
                    scan_start_nxt = wd[bds_pkg::SCAN_START_BIT];
                end
                bds_pkg::OFS_ALERT_CFG:    alert_cfg_nxt   = wd[4:0];
                bds_pkg::OFS_TEMP_THRESH:  temp_thresh_nxt = wd[13:0];
                bds_pkg::OFS_OPEN_THRESH:  open_thresh_nxt = wd[13:0];
                bds_pkg::OFS_BIPOLAR_MASK: bipolar_nxt     = wd[NCELL-1:0];
                bds_pkg::OFS_CTEST_CFG: begin
                    ctest_en_nxt  = wd[NCELL-1:0];
                    ctest_dac_nxt = wd[bds_pkg::CTEST_DAC_LSB +: 4];
                end
                bds_pkg::OFS_FAULT_ONE:    fault_one_nxt   = fault_one_r & ~wd[1:0];
                bds_pkg::OFS_FAULT_TWO:    fault_two_nxt   = fault_two_r & ~wd[2:0];
                bds_pkg::OFS_BALSW_ALERT:  balsw_nxt       = balsw_r & ~wd[NCELL-1:0];
                bds_pkg::OFS_COMP_OV:      comp_ov_nxt     = comp_ov_r & ~wd[NCELL-1:0];
                bds_pkg::OFS_COMM_STATUS:  comm_nxt        = comm_r & ~wd[1:0];
                default: ;
            endcase
        end

        // Receive-port check, once after reset.
        if (!comm_checked_r) begin
            comm_nxt[bds_pkg::COMM_UPPER_BIT] = ~pin_s2_r[0];
            comm_nxt[bds_pkg::COMM_LOWER_BIT] = ~pin_s2_r[1];
        end
        if (pin_s2_r[2]) begin
            fault_one_nxt[bds_pkg::F1_SUPPLY_MUX_BIT] = 1'b1;
        end
        if (acq_done) begin
            fault_two_nxt[bds_pkg::F2_ACC_OV_BIT] = acc_code > temp_thresh_r;
            fault_two_nxt[bds_pkg::F2_ACC_UV_BIT] = acc_code < open_thresh_r;
        end
        if (tick_r == 32'd0 && !temp_suspend && die_temp_code > temp_thresh_r) begin
            fault_two_nxt[bds_pkg::F2_TEMP_BIT] = 1'b1;
        end
        if (balsw_done) begin
            balsw_nxt = balsw_nxt | balsw_fail;
            fault_one_nxt[bds_pkg::F1_SUMMARY_BIT] = |(balsw_nxt | balsw_fail);
        end
        if (comp_scan_done && open_diag) begin
            comp_ov_nxt = comp_ov_nxt | open_hits;
        end
        if (conv_done) begin
            if (!slot_r) begin
                result_a_nxt = {adc_result.code, 2'b00};
            end else begin
                result_b_nxt = {adc_result.code, 2'b00};
            end
        end

        if (rd_en) begin
            case (avs_address)
                bds_pkg::OFS_DIAG_CFG:     rdata_nxt = {24'h0, diag_cfg_r};
                bds_pkg::OFS_SCAN_CTRL:    rdata_nxt = {28'h0, scan_ctrl_r};
                bds_pkg::OFS_ALERT_CFG:    rdata_nxt = {27'h0, alert_cfg_r};
                bds_pkg::OFS_TEMP_THRESH:  rdata_nxt = {18'h0, temp_thresh_r};
                bds_pkg::OFS_OPEN_THRESH:  rdata_nxt = {18'h0, open_thresh_r};
                bds_pkg::OFS_BIPOLAR_MASK: rdata_nxt = 32'(bipolar_r);
                bds_pkg::OFS_CTEST_CFG:    rdata_nxt = {12'h0, ctest_dac_r, 16'(ctest_en_r)};
                bds_pkg::OFS_RESULT_A:     rdata_nxt = {16'h0, result_a_r};
                bds_pkg::OFS_RESULT_B:     rdata_nxt = {16'h0, result_b_r};
                bds_pkg::OFS_FAULT_ONE:    rdata_nxt = {30'h0, fault_one_r};
                bds_pkg::OFS_FAULT_TWO:    rdata_nxt = {29'h0, fault_two_r};
                bds_pkg::OFS_BALSW_ALERT:  rdata_nxt = 32'(balsw_r);
                bds_pkg::OFS_COMP_OV:      rdata_nxt = 32'(comp_ov_r);
                bds_pkg::OFS_COMM_STATUS:  rdata_nxt = {30'h0, comm_r};
                default:                   rdata_nxt = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Diagnostic sequencer next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [3:0] cur;
        cur      = slot_r ? sel_b : sel_a;
        st_nxt   = st_r;
        slot_nxt = slot_r;
        cnt_nxt  = cnt_r;
        tick_nxt = (tick_r == 32'(TEMP_PERIOD - 1)) ? 32'd0 : tick_r + 32'd1;
        case (st_r)
            bds_pkg::ST_IDLE: begin
                // Alternate between the two selects; a zero select is skipped.
                if (cur != bds_pkg::DSEL_NONE) begin
                    st_nxt  = bds_pkg::ST_SETTLE;
                    cnt_nxt = 32'd0;
                end else begin
                    slot_nxt = ~slot_r;
                end
            end
            bds_pkg::ST_SETTLE: begin
                cnt_nxt = cnt_r + 32'd1;
                // A select cleared to zero mid-flight abandons the diagnostic.
                if (cur == bds_pkg::DSEL_NONE) begin
                    st_nxt = bds_pkg::ST_IDLE;
                end else if (cur != bds_pkg::DSEL_PTAT || cnt_r >= 32'(SETTLE - 1)) begin
                    st_nxt = bds_pkg::ST_CONV;
                end
            end
            bds_pkg::ST_CONV: begin
                if (cur == bds_pkg::DSEL_NONE) begin
                    st_nxt = bds_pkg::ST_IDLE;
                end else if (adc_result.valid) begin
                    st_nxt   = bds_pkg::ST_IDLE;
                    slot_nxt = ~slot_r;
                end
            end
            default: st_nxt = bds_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b_r) begin
        if (!rst_b_r) begin
            diag_cfg_r     <= 8'h00;
            scan_ctrl_r    <= 4'h0;
            alert_cfg_r    <= 5'h00;
            temp_thresh_r  <= 14'h3FFF;
            open_thresh_r  <= 14'h0000;
            bipolar_r      <= '0;
            ctest_en_r     <= '0;
            ctest_dac_r    <= 4'h0;
            result_a_r     <= 16'h0000;
            result_b_r     <= 16'h0000;
            fault_one_r    <= 2'h0;
            fault_two_r    <= 3'h0;
            balsw_r        <= '0;
            comp_ov_r      <= '0;
            comm_r         <= 2'h0;
            comm_checked_r <= 1'b0;
            scan_start_r   <= 1'b0;
            rdata_r        <= 32'h0;
            ack_r          <= 1'b0;
            st_r           <= bds_pkg::ST_IDLE;
            slot_r         <= 1'b0;
            cnt_r          <= 32'd0;
            tick_r         <= 32'd0;
        end else begin
            diag_cfg_r     <= diag_cfg_nxt;
            scan_ctrl_r    <= scan_ctrl_nxt;
            alert_cfg_r    <= alert_cfg_nxt;
            temp_thresh_r  <= temp_thresh_nxt;
            open_thresh_r  <= open_thresh_nxt;
            bipolar_r      <= bipolar_nxt;
            ctest_en_r     <= ctest_en_nxt;
            ctest_dac_r    <= ctest_dac_nxt;
            result_a_r     <= result_a_nxt;
            result_b_r     <= result_b_nxt;
            fault_one_r    <= fault_one_nxt;
            fault_two_r    <= fault_two_nxt;
            balsw_r        <= balsw_nxt;
            comp_ov_r      <= comp_ov_nxt;
            comm_r         <= comm_nxt;
            comm_checked_r <= comm_checked_nxt;
            scan_start_r   <= scan_start_nxt;
            rdata_r        <= rdata_nxt;
            ack_r          <= ack_nxt;
            st_r           <= st_nxt;
            slot_r         <= slot_nxt;
            cnt_r          <= cnt_nxt;
            tick_r         <= tick_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Front-end steering
    // ------------------------------------------------------------------
    logic [3:0] conv_sel;
    assign conv_sel = slot_r ? sel_b : sel_a;

    always_comb begin
        adc_mux_select     = (st_r == bds_pkg::ST_IDLE) ? bds_pkg::DSEL_NONE : conv_sel;
        adc_start          = (st_r == bds_pkg::ST_SETTLE) & (st_nxt == bds_pkg::ST_CONV);
        adc_ref_supply     = (adc_mux_select == bds_pkg::DSEL_SUPPLY);
        adc_force_unipolar = (adc_mux_select == bds_pkg::DSEL_ALTERNATE_REFERENCE);
        case (adc_mux_select)
            bds_pkg::DSEL_DAC_HIGH: dac_code = bds_pkg::DAC_HIGH_CODE;
            bds_pkg::DSEL_DAC_LOW:  dac_code = bds_pkg::DAC_LOW_CODE;
            default:                dac_code = 14'h0000;
        endcase
        balsw_mode      = scan_ctrl_r[2:0] >= bds_pkg::SCAN_SW_SHORT ? scan_ctrl_r[2:0] : 3'h0;
        pulldown_enable = (open_diag | balsw_mode != 3'h0) ? ctest_en_r : '0;
        pulldown_level  = ctest_dac_r;
        // The pin is driven only while the DC test is on, and only with the UART interface selected (ACFG_IFSEL_BIT set).
        alert_output_pin_oe = dc_test;
        alert_output_pin_o  = ~(alert_condition | alert_cfg_r[bds_pkg::ACFG_USER_BIT]);
    end

endmodule : bds_top

/* File: tb/bds_asserts.sv */
`timescale 1ns/1ps
module bds_asserts (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [3:0]  adc_mux_select,
    input wire logic        adc_start,
    input wire logic        adc_ref_supply,
    input wire logic        adc_force_unipolar,
    input wire logic [13:0] dac_code,
    input wire logic [2:0]  balsw_mode,
    input wire logic        alert_condition,
    input wire logic        alert_output_pin_o,
    input wire logic        alert_output_pin_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_dac_high: assert property (adc_mux_select == 4'h7 |-> dac_code == 14'h06EC) else $error("dac high");
    a_dac_low: assert property (adc_mux_select == 4'h8 |-> dac_code == 14'h024F) else $error("dac low");
    a_dac_rest: assert property (!(adc_mux_select inside {4'h7, 4'h8}) |-> dac_code == 14'h0000)
        else $error("dac idle");
    a_ref_supply: assert property (adc_ref_supply |-> adc_mux_select == 4'h2) else $error("ref supply");
    a_unipolar_forced: assert property (adc_force_unipolar |-> adc_mux_select == 4'h3) else $error("unipolar");
    a_idle_start: assert property (adc_mux_select == 4'h0 |-> !adc_start) else $error("start when idle");
    a_start_pulse: assert property (adc_start |=> !adc_start) else $error("start too long");
    a_balsw_code: assert property (balsw_mode != 3'h0 |-> balsw_mode[2]) else $error("balsw code");
    a_pin_level: assert property (alert_output_pin_oe && alert_condition && $past(alert_condition)
        |-> !alert_output_pin_o) else $error("pin not low");
endmodule : bds_asserts

/* File: tb/bds_top_tb_top.sv */
`timescale 1ns/1ps
module bds_top_tb_top;
    logic clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [7:0]  avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, q;
    logic [3:0]  avs_byteenable = 4'hF, adc_mux_select, pulldown_level;
    logic        adc_start, adc_ref_supply, adc_force_unipolar, acq_done = 0, comp_scan_done = 0;
    logic [13:0] dac_code, die_temp_code = 0, acc_code = 0, balsw_fail = 0, pulldown_enable;
    logic [13:0] cell_code [14];
    logic [2:0]  balsw_mode;
    logic        balsw_done = 0, rx_upper_ok_pin = 1, rx_lower_ok_pin = 0, flex_pack_fault_pin = 0;
    logic        alert_condition = 0, alert_output_pin_o, alert_output_pin_oe;
    bds_pkg::bds_adc_type adc_result = '0;
    int mismatches = 0, checks_done = 0, cyc = 0;
    logic [3:0]  codes [9] = '{4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};

    bds_top #(.NCELL(14), .TEMP_PERIOD(50), .SETTLE(5)) dut (.*);

    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
    endtask : bus

    task result(input logic [13:0] v);
        adc_result <= {1'b1, v};
        @(posedge clk);
        adc_result <= '0;
    endtask : result

    task t_diag;
        logic [3:0]  c;
        logic [13:0] v;
        for (int i = 0; i < 9; i++) begin
            c = codes[i];
            v = c == 4'h2 ? 14'h1400 : c == 4'h3 ? 14'h0FE0 : {c, 10'h155};
            bus(1, bds_pkg::OFS_DIAG_CFG, {28'h0, c});
            for (int n = 0; n < 100 && adc_start !== 1'b1; n++) @(posedge clk);
            chk("mux", {28'h0, c}, {28'h0, adc_mux_select});
            chk("ref", {31'h0, c == 4'h2}, {31'h0, adc_ref_supply});
            chk("uni", {31'h0, c == 4'h3}, {31'h0, adc_force_unipolar});
            chk("dac", c == 4'h7 ? 32'h06EC : c == 4'h8 ? 32'h024F : 32'h0, {18'h0, dac_code});
            result(v);
            bus(1, bds_pkg::OFS_DIAG_CFG, 32'h0);
            result(14'h0AAA);
            bus(0, bds_pkg::OFS_RESULT_A, 32'h0);
            chk("res", {16'h0, v, 2'b00}, q);
        end
    endtask : t_diag

    task t_pin(input logic [31:0] cfg, input logic cond, input logic oe, input logic pin);
        alert_condition <= cond;
        bus(1, bds_pkg::OFS_ALERT_CFG, cfg);
        repeat (3) @(posedge clk);
        chk("oe", {31'h0, oe}, {31'h0, alert_output_pin_oe});
        if (oe) chk("pin", {31'h0, pin}, {31'h0, alert_output_pin_o});
    endtask : t_pin

    task t_scan;
        cell_code[0] <= 14'h0010;
        cell_code[1] <= 14'h0010;
        bus(1, bds_pkg::OFS_OPEN_THRESH, 32'h100);
        bus(1, bds_pkg::OFS_BIPOLAR_MASK, 32'h2);
        bus(1, bds_pkg::OFS_ALERT_CFG, 32'h10);
        bus(1, bds_pkg::OFS_SCAN_CTRL, 32'h12);
        bus(1, bds_pkg::OFS_CTEST_CFG, 32'h0003_0005);
        @(posedge clk);
        chk("pd_en", 32'h5, {18'h0, pulldown_enable});
        chk("pd_lvl", 32'h3, {28'h0, pulldown_level});
        comp_scan_done <= 1;
        @(posedge clk);
        comp_scan_done <= 0;
        bus(0, bds_pkg::OFS_COMP_OV, 32'h0);
        chk("open", 32'h1, q);
        for (int c = 4; c < 8; c++) begin
            bus(1, bds_pkg::OFS_SCAN_CTRL, 32'h10 | c);
            @(posedge clk);
            chk("mode", c, {29'h0, balsw_mode});
            balsw_fail <= 14'h1 << c;
            balsw_done <= 1;
            @(posedge clk);
            balsw_done <= 0;
        end
        bus(1, bds_pkg::OFS_SCAN_CTRL, 32'h0);
        @(posedge clk);
        chk("pd_off", 32'h0, {18'h0, pulldown_enable});
        flex_pack_fault_pin <= 1;
        bus(0, bds_pkg::OFS_BALSW_ALERT, 32'h0);
        chk("sw", 32'hF0, q);
        bus(0, bds_pkg::OFS_FAULT_ONE, 32'h0);
        chk("f1", 32'h3, q & 32'h3);
        bus(0, bds_pkg::OFS_COMM_STATUS, 32'h0);
        chk("comm", 32'h2, q);
        bus(0, 8'hFC, 32'h0);
        chk("unmapped", 32'h0, q);
    endtask : t_scan

    task acc(input logic [13:0] v, input logic [31:0] e);
        acc_code <= v;
        acq_done <= 1;
        @(posedge clk);
        acq_done <= 0;
        bus(0, bds_pkg::OFS_FAULT_TWO, 32'h0);
        chk("acc", e, q & 32'h6);
    endtask : acc

    task t_temp;
        bus(1, bds_pkg::OFS_DIAG_CFG, 32'h1);
        die_temp_code <= 14'h0200;
        bus(1, bds_pkg::OFS_TEMP_THRESH, 32'h100);
        repeat (120) @(posedge clk);
        bus(0, bds_pkg::OFS_FAULT_TWO, 32'h0);
        chk("tsusp", 32'h0, q & 32'h1);
        result(14'h0123);
        bus(1, bds_pkg::OFS_DIAG_CFG, 32'h0);
        repeat (120) @(posedge clk);
        bus(0, bds_pkg::OFS_FAULT_TWO, 32'h0);
        chk("talert", 32'h1, q & 32'h1);
        acc(14'h0300, 32'h2);
        acc(14'h0050, 32'h4);
    endtask : t_temp

    task conclude;
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude

    initial begin
        foreach (cell_code[i]) cell_code[i] = 14'h2000;
        repeat (6) @(posedge clk);
        rst_b <= 1;
        repeat (3) @(posedge clk);
        t_diag();
        t_pin(32'h3, 1, 1, 0);
        t_pin(32'h3, 0, 1, 1);
        t_pin(32'h7, 0, 1, 0);
        t_pin(32'h2, 1, 0, 0);
        t_scan();
        t_temp();
        conclude();
    end
endmodule : bds_top_tb_top

bind bds_top bds_asserts chk_i (.*);
